// ==== fmac_core.sv ====
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// frame memory address counter with apb register access
// Overview of operation
// - write or read start reloads both counters
// - each pixel advances column, page unchanged
// - column past end: back to start, page+1
// - both past end: stop or wrap by setting
// - pixel bytes: red high, green mid, blue low
// - host pixel order independent of orientation
// - one pixel uses one column, one page
// - exchange, column invert, page invert all supported
// - tear off/on commands set tear enable flag
// - tear disabled holds tear pin low
// - tear mode bit selects first or second
// - invert gives 319-col or 479-page; exchange swaps
// - memory holds 480 by 320 24-bit pixels
// - display area columns 0-13F, pages 0-1DF
module fmac_core
  import fmac_pkg::*;
#(
  parameter int COLS        = 320,
  parameter int PAGES       = 480,
  parameter int LINE_CYCLES = fmac_pkg::FMAC_LINE_CYCLES,
  parameter int LINE_ACTIVE = fmac_pkg::FMAC_LINE_ACTIVE,
  parameter int PORCH_LINES = fmac_pkg::FMAC_PORCH_LINES
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  output logic              tear_sync_pin
);
  import fmac_pkg::*;

  localparam int DEPTH     = COLS * PAGES;
  localparam int AW        = $clog2(DEPTH);
  localparam int LINES     = PAGES + PORCH_LINES;
  localparam logic [8:0] COL_MAX  = 9'(COLS - 1);
  localparam logic [8:0] PAGE_MAX = 9'(PAGES - 1);

  // ==========================================================================
  // elaboration checks
  generate
    if (COLS < 2 || COLS > 512 || PAGES < 2 || PAGES > 512) begin : g_bad_geom
      $error("fmac_core: COLS and PAGES must lie in 2..512");
    end
    if (LINE_ACTIVE < 1 || LINE_ACTIVE >= LINE_CYCLES || LINE_CYCLES > 65535) begin : g_bad_line
      $error("fmac_core: need 1 <= LINE_ACTIVE < LINE_CYCLES <= 65535");
    end
    if (PORCH_LINES < 1 || LINES > 1023) begin : g_bad_porch
      $error("fmac_core: porch lines out of range");
    end
    // each 9-bit pointer must fit its field without touching the next one
    if (FMAC_WIN_END_LSB < FMAC_WIN_START_LSB + 9 || FMAC_WIN_END_LSB > 23) begin : g_bad_win
      $error("fmac_core: window fields overlap or overflow");
    end
    if (FMAC_STAT_PAGE_LSB < FMAC_STAT_COL_LSB + 9 || FMAC_STAT_STOP_BIT < FMAC_STAT_PAGE_LSB + 9) begin : g_bad_stat
      $error("fmac_core: status fields overlap");
    end
  endgenerate

  // ==========================================================================
  // state
  typedef struct packed {
    logic        wrap;
    logic        exch;
    logic        cinv;
    logic        pinv;
    logic        tmode;
    logic        ten;
    logic [8:0]  col_start;
    logic [8:0]  col_end;
    logic [8:0]  pg_start;
    logic [8:0]  pg_end;
    logic [8:0]  col_cnt;
    logic [8:0]  pg_cnt;
    logic        stopped;
    logic        rd_wait;
    logic        mem_ok;
    logic [31:0] rdata;
    logic [15:0] dot_cnt;
    logic [9:0]  line_cnt;
    logic        tear;
  } fmac_state_t;

  fmac_state_t state_reg;
  fmac_state_t state_next;

  logic [23:0] frame_mem [DEPTH];
  logic [23:0] mem_q;

  // ==========================================================================
  // decode helpers
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      FMAC_CTRL_OFF, FMAC_COL_WIN_OFF, FMAC_PAGE_WIN_OFF,
      FMAC_CMD_OFF, FMAC_PIXEL_OFF, FMAC_STATUS_OFF: addr_mapped = 1'b1;
      default:                                        addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [8:0] win_start(input logic [31:0] d);
    win_start = d[FMAC_WIN_START_LSB +: 9];
  endfunction

  function automatic logic [8:0] win_end(input logic [31:0] d);
    win_end = d[FMAC_WIN_END_LSB +: 9];
  endfunction

  // pixel port decode shared by the read wait state and the counter step
  function automatic logic is_pixel(input logic [7:0] a);
    is_pixel = (a == FMAC_PIXEL_OFF);
  endfunction

  // ==========================================================================
  // counter to physical pointer mapping
  logic [8:0]    phys_col;
  logic [8:0]    phys_page;
  logic          phys_ok;
  logic [AW-1:0] phys_addr;

  always_comb begin
    logic [8:0] x;
    logic [8:0] y;
    x = state_reg.exch ? state_reg.pg_cnt : state_reg.col_cnt;
    y = state_reg.exch ? state_reg.col_cnt : state_reg.pg_cnt;
    phys_ok   = (x <= COL_MAX) && (y <= PAGE_MAX);
    phys_col  = state_reg.cinv ? 9'(COL_MAX - x) : x;
    phys_page = state_reg.pinv ? 9'(PAGE_MAX - y) : y;
    phys_addr = AW'(phys_page) * AW'(COLS) + AW'(phys_col);
  end

  // ==========================================================================
  // bus phases
  logic setup_ph;
  logic access_ph;
  logic pix_rd;
  logic done;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign pix_rd    = !pwrite && is_pixel(paddr);
  // a pixel read needs one wait state so the memory word can reach prdata
  assign pready    = !(access_ph && pix_rd && !state_reg.rd_wait);
  assign pslverr   = access_ph && !addr_mapped(paddr);
  assign done      = access_ph && pready;
  assign prdata    = state_reg.rdata;

  // one pixel moved over the bus and counters are live
  logic pix_step;
  assign pix_step = done && is_pixel(paddr) && !state_reg.stopped;

  // ==========================================================================
  // scan position for the tear output
  logic vblank;
  logic hblank;

  assign vblank = (state_reg.line_cnt >= 10'(PAGES));
  assign hblank = (state_reg.dot_cnt >= 16'(LINE_ACTIVE));

  // ==========================================================================
  // frame memory: low 24 bits of the host word stored as given, red in bits 23:16
  always_ff @(posedge pclk) begin
    if (pix_step && pwrite && phys_ok) begin
      frame_mem[phys_addr] <= pwdata[23:0];
    end
    if (setup_ph && pix_rd && phys_ok) begin
      mem_q <= frame_mem[phys_addr];
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_next = state_reg;

    // read data captured in setup so prdata is a flop during access
    if (setup_ph && !pwrite) begin
      case (paddr)
        FMAC_CTRL_OFF: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rdata[FMAC_CTRL_WRAP_BIT]  = state_reg.wrap;
          state_next.rdata[FMAC_CTRL_EXCH_BIT]  = state_reg.exch;
          state_next.rdata[FMAC_CTRL_CINV_BIT]  = state_reg.cinv;
          state_next.rdata[FMAC_CTRL_PINV_BIT]  = state_reg.pinv;
          state_next.rdata[FMAC_CTRL_TMODE_BIT] = state_reg.tmode;
        end
        FMAC_COL_WIN_OFF: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rdata[FMAC_WIN_START_LSB +: 9] = state_reg.col_start;
          state_next.rdata[FMAC_WIN_END_LSB +: 9]   = state_reg.col_end;
        end
        FMAC_PAGE_WIN_OFF: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rdata[FMAC_WIN_START_LSB +: 9] = state_reg.pg_start;
          state_next.rdata[FMAC_WIN_END_LSB +: 9]   = state_reg.pg_end;
        end
        FMAC_STATUS_OFF: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rdata[FMAC_STAT_COL_LSB +: 9]  = state_reg.col_cnt;
          state_next.rdata[FMAC_STAT_PAGE_LSB +: 9] = state_reg.pg_cnt;
          state_next.rdata[FMAC_STAT_STOP_BIT]      = state_reg.stopped;
          state_next.rdata[FMAC_STAT_TEN_BIT]       = state_reg.ten;
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // pixel read: memory word lands after the wait state
    // an out-of-range fetch must not hand back a stale word
    if (setup_ph && pix_rd) begin
      state_next.mem_ok = phys_ok;
    end
    state_next.rd_wait = access_ph && pix_rd && !state_reg.rd_wait;
    if (access_ph && pix_rd && !state_reg.rd_wait) begin
      state_next.rdata = {8'h00, ((state_reg.stopped || !state_reg.mem_ok) ? 24'h00_0000 : mem_q)};
    end

    // register writes take effect at the completing edge
    if (done && pwrite) begin
      case (paddr)
        FMAC_CTRL_OFF: begin
          state_next.wrap  = pwdata[FMAC_CTRL_WRAP_BIT];
          state_next.exch  = pwdata[FMAC_CTRL_EXCH_BIT];
          state_next.cinv  = pwdata[FMAC_CTRL_CINV_BIT];
          state_next.pinv  = pwdata[FMAC_CTRL_PINV_BIT];
          state_next.tmode = pwdata[FMAC_CTRL_TMODE_BIT];
        end
        FMAC_COL_WIN_OFF: begin
          state_next.col_start = win_start(pwdata);
          state_next.col_end   = win_end(pwdata);
        end
        FMAC_PAGE_WIN_OFF: begin
          state_next.pg_start = win_start(pwdata);
          state_next.pg_end   = win_end(pwdata);
        end
        FMAC_CMD_OFF: begin
          case (pwdata[7:0])
            FMAC_CMD_MEM_WRITE, FMAC_CMD_MEM_READ: begin
              state_next.col_cnt = state_reg.col_start;
              state_next.pg_cnt  = state_reg.pg_start;
              state_next.stopped = 1'b0;
            end
            FMAC_CMD_TEAR_OFF: state_next.ten = 1'b0;
            FMAC_CMD_TEAR_ON:  state_next.ten = 1'b1;
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // counter advance after each pixel, same for reads and writes
    if (pix_step) begin
      if (state_reg.col_cnt >= state_reg.col_end) begin
        if (state_reg.pg_cnt >= state_reg.pg_end) begin
          if (state_reg.wrap) begin
            state_next.col_cnt = state_reg.col_start;
            state_next.pg_cnt  = state_reg.pg_start;
          end else begin
            state_next.stopped = 1'b1;
          end
        end else begin
          state_next.col_cnt = state_reg.col_start;
          state_next.pg_cnt  = 9'(state_reg.pg_cnt + 9'h001);
        end
      end else begin
        state_next.col_cnt = 9'(state_reg.col_cnt + 9'h001);
      end
    end

    // ==========================================================================
    // panel scan timer driving the tear output
    if (state_reg.dot_cnt == 16'(LINE_CYCLES - 1)) begin
      state_next.dot_cnt = 16'h0000;
      if (state_reg.line_cnt == 10'(LINES - 1)) begin
        state_next.line_cnt = 10'h000;
      end else begin
        state_next.line_cnt = 10'(state_reg.line_cnt + 10'h001);
      end
    end else begin
      state_next.dot_cnt = 16'(state_reg.dot_cnt + 16'h0001);
    end

    // first mode marks vertical blanking, second adds each line blank
    if (!state_reg.ten) begin
      state_next.tear = 1'b0;
    end else if (!state_reg.tmode) begin
      state_next.tear = vblank;
    end else begin
      state_next.tear = vblank || hblank;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.wrap      <= FMAC_CTRL_RST[FMAC_CTRL_WRAP_BIT];
      state_reg.exch      <= FMAC_CTRL_RST[FMAC_CTRL_EXCH_BIT];
      state_reg.cinv      <= FMAC_CTRL_RST[FMAC_CTRL_CINV_BIT];
      state_reg.pinv      <= FMAC_CTRL_RST[FMAC_CTRL_PINV_BIT];
      state_reg.tmode     <= FMAC_CTRL_RST[FMAC_CTRL_TMODE_BIT];
      state_reg.ten       <= 1'b0;
      state_reg.col_start <= FMAC_START_RST;
      state_reg.col_end   <= FMAC_COL_LAST_RST;
      state_reg.pg_start  <= FMAC_START_RST;
      state_reg.pg_end    <= FMAC_PAGE_LAST_RST;
      state_reg.col_cnt   <= FMAC_START_RST;
      state_reg.pg_cnt    <= FMAC_START_RST;
      state_reg.stopped   <= 1'b0;
      state_reg.rd_wait   <= 1'b0;
      state_reg.mem_ok    <= 1'b0;
      state_reg.rdata     <= 32'h0000_0000;
      state_reg.dot_cnt   <= 16'h0000;
      state_reg.line_cnt  <= 10'h000;
      state_reg.tear      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tear_sync_pin = state_reg.tear;

endmodule

`default_nettype wire

// ==== fmac_core_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port-level checks of the address counter and tear output
module fmac_core_props
  import fmac_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        tear_sync_pin
);
  logic        wr_done, rd_done, ten, ten_d1, ten_d2, mode2, reload, seen_stop;
  logic [31:0] cw, pw;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  // shadow of what software asked for, so reads can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ten, ten_d1, ten_d2, mode2, reload, seen_stop} <= 6'h00;
      cw <= 32'h013F0000;
      pw <= 32'h01DF0000;
    end else begin
      ten_d1 <= ten;
      ten_d2 <= ten_d1;
      if (wr_done && paddr == FMAC_CMD_OFF && pwdata[7:0] == FMAC_CMD_TEAR_ON) ten <= 1'b1;
      if (wr_done && paddr == FMAC_CMD_OFF && pwdata[7:0] == FMAC_CMD_TEAR_OFF) ten <= 1'b0;
      if (psel && penable && pready && paddr == FMAC_PIXEL_OFF) reload <= 1'b0;
      if (rd_done && paddr == FMAC_STATUS_OFF && prdata[28]) seen_stop <= 1'b1;
      if (wr_done && paddr == FMAC_CMD_OFF &&
          (pwdata[7:0] == FMAC_CMD_MEM_WRITE || pwdata[7:0] == FMAC_CMD_MEM_READ)) begin
        reload    <= 1'b1;
        seen_stop <= 1'b0;
      end
      if (wr_done && paddr == FMAC_CTRL_OFF) mode2 <= pwdata[4];
      if (wr_done && paddr == FMAC_COL_WIN_OFF) cw <= pwdata & 32'h01FF01FF;
      if (wr_done && paddr == FMAC_PAGE_WIN_OFF) pw <= pwdata & 32'h01FF01FF;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence mode1_high; tear_sync_pin [*8]; endsequence
  sequence pin_low4; !tear_sync_pin [*4]; endsequence
  chk_tear_low: assert property (!ten && !ten_d1 && !ten_d2 |-> !tear_sync_pin)
    else $error("tear pin high while disabled");
  chk_tear_off: assert property (wr_done && paddr == FMAC_CMD_OFF && pwdata[7:0] == 8'h34 |=> ##1 pin_low4)
    else $error("tear pin not low after tear off");
  chk_status_ten: assert property (rd_done && paddr == FMAC_STATUS_OFF |-> prdata[29] == ten)
    else $error("tear enable status wrong");
  chk_mode1_pulse: assert property ($rose(tear_sync_pin) && !mode2 && $past(ten_d2) |-> mode1_high)
    else $error("first tear mode pulse too short");
  chk_reload_start: assert property (rd_done && paddr == FMAC_STATUS_OFF && reload |->
    prdata[8:0] == cw[8:0] && prdata[24:16] == pw[8:0] && !prdata[28])
    else $error("counters not at window start");
  chk_window_regs: assert property (rd_done && (paddr == FMAC_COL_WIN_OFF || paddr == FMAC_PAGE_WIN_OFF) |->
    prdata == ((paddr == FMAC_COL_WIN_OFF) ? cw : pw))
    else $error("window register read wrong");
  chk_stopped_zero: assert property (rd_done && paddr == FMAC_PIXEL_OFF && seen_stop |-> prdata == 32'h0)
    else $error("pixel read while stopped not zero");
  chk_pixel_lanes: assert property (rd_done && paddr == FMAC_PIXEL_OFF |-> prdata[31:24] == 8'h00)
    else $error("pixel top byte not zero");
endmodule
bind fmac_core fmac_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .tear_sync_pin(tear_sync_pin));
`default_nettype wire

// ==== fmac_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host processor: apb master issuing commands and pixel words
module fmac_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        tear_sync_pin,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // pixel words are packed red, green, blue from bits 23:16 down; the top byte is unused
  // pixel order never depends on orientation parallel bus, so exchange may be set
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready is judged at the rising edge itself; a pixel read adds a wait state
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_tear();
    for (int i = 0; i < 8000 && tear_sync_pin !== 1'b1; i++) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== fmac_pkg.sv ====
// ==========================================================================
// frame memory address counter constants
package fmac_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] FMAC_CTRL_OFF     = 8'h00;
  localparam logic [7:0] FMAC_COL_WIN_OFF  = 8'h04;
  localparam logic [7:0] FMAC_PAGE_WIN_OFF = 8'h08;
  localparam logic [7:0] FMAC_CMD_OFF      = 8'h0C;
  localparam logic [7:0] FMAC_PIXEL_OFF    = 8'h10;
  localparam logic [7:0] FMAC_STATUS_OFF   = 8'h14;

  // ==========================================================================
  // control field positions
  localparam int FMAC_CTRL_WRAP_BIT  = 0;
  localparam int FMAC_CTRL_EXCH_BIT  = 1;
  localparam int FMAC_CTRL_CINV_BIT  = 2;
  localparam int FMAC_CTRL_PINV_BIT  = 3;
  localparam int FMAC_CTRL_TMODE_BIT = 4;

  // window registers: start in [8:0], end in [24:16]
  localparam int FMAC_WIN_START_LSB = 0;
  localparam int FMAC_WIN_END_LSB   = 16;

  // status field positions
  localparam int FMAC_STAT_COL_LSB  = 0;
  localparam int FMAC_STAT_PAGE_LSB = 16;
  localparam int FMAC_STAT_STOP_BIT = 28;
  localparam int FMAC_STAT_TEN_BIT  = 29;

  // pixel colour lanes
  localparam int FMAC_RED_LSB   = 16;
  localparam int FMAC_GREEN_LSB = 8;
  localparam int FMAC_BLUE_LSB  = 0;

  // ==========================================================================
  // command codes
  localparam logic [7:0] FMAC_CMD_TEAR_OFF  = 8'h34;
  localparam logic [7:0] FMAC_CMD_TEAR_ON   = 8'h35;
  localparam logic [7:0] FMAC_CMD_MEM_WRITE = 8'h2C;
  localparam logic [7:0] FMAC_CMD_MEM_READ  = 8'h2E;

  // ==========================================================================
  // geometry and reset values
  localparam logic [8:0] FMAC_COL_LAST_RST  = 9'h13F;
  localparam logic [8:0] FMAC_PAGE_LAST_RST = 9'h1DF;
  localparam logic [8:0] FMAC_START_RST     = 9'h000;
  localparam logic [4:0] FMAC_CTRL_RST      = 5'h00;

  // ==========================================================================
  // scan timing used for the tear output
  localparam int FMAC_PORCH_LINES  = 16;
  localparam int FMAC_LINE_CYCLES  = 200;
  localparam int FMAC_LINE_ACTIVE  = 160;

endpackage

// ==== frame_memory_address_counter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench: host model drives, a monitor compares each read against its note
module frame_memory_address_counter_tb;
  import fmac_pkg::*;
  localparam int FRAME = (480 + 2) * 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tear_sync_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] exp_q[$];
  logic [31:0] pix [6];
  int          num_errors, n_tests;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  fmac_core #(.LINE_CYCLES(8), .LINE_ACTIVE(6), .PORCH_LINES(2)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .tear_sync_pin(tear_sync_pin));
  fmac_host host (.pclk(pclk), .pready(pready), .tear_sync_pin(tear_sync_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    host.xfer(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] win(input logic [8:0] s, input logic [8:0] e);
    return {7'h00, e, 7'h00, s};
  endfunction
  function automatic logic [31:0] stat(input logic [8:0] c, input logic [8:0] p, input logic s, input logic t);
    return {2'b00, t, s, 3'b000, p, 7'h00, c};
  endfunction
  task count_rises(output int n);
    logic prev;
    n = 0;
    prev = tear_sync_pin;
    repeat (FRAME) begin
      @(negedge pclk);
      if (tear_sync_pin === 1'b1 && prev !== 1'b1) n++;
      prev = tear_sync_pin;
    end
  endtask
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check("slave error", {31'h0, pslverr}, {31'h0, ((paddr > FMAC_STATUS_OFF) || (paddr[1:0] != 2'b00))});
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else check("read data", prdata, exp_q.pop_front());
    end
  end
  initial begin
    #900000;
    num_errors++;
    stop_test();
  end
  initial begin
    logic [31:0] v;
    logic [8:0]  c, p, x, y;
    logic        stp;
    int          n;
    presetn = 1'b0;
    num_errors = 0;
    n_tests = 0;
    v = $urandom(48);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(FMAC_CTRL_OFF, 32'h0);
    rd(FMAC_COL_WIN_OFF, win(9'h000, 9'h13F));
    rd(FMAC_PAGE_WIN_OFF, win(9'h000, 9'h1DF));
    rd(FMAC_STATUS_OFF, 32'h0);
    rd(8'h18, 32'h0);
    // small window, stop at the end; the seventh pixel must be dropped
    wr(FMAC_COL_WIN_OFF, win(9'd2, 9'd4));
    wr(FMAC_PAGE_WIN_OFF, win(9'd5, 9'd6));
    wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_MEM_WRITE});
    c = 9'd2;
    p = 9'd5;
    stp = 1'b0;
    for (int i = 0; i < 7; i++) begin
      v = $urandom();
      if (i < 6) pix[i] = v & 32'h00FFFFFF;
      wr(FMAC_PIXEL_OFF, v);
      if (!stp && c >= 9'd4 && p >= 9'd6) stp = 1'b1;
      else if (!stp && c >= 9'd4) begin
        c = 9'd2;
        p = p + 9'd1;
      end else if (!stp) c = c + 9'd1;
      rd(FMAC_STATUS_OFF, stat(c, p, stp, 1'b0));
    end
    wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_MEM_READ});
    rd(FMAC_STATUS_OFF, stat(9'd2, 9'd5, 1'b0, 1'b0));
    for (int i = 0; i < 6; i++) rd(FMAC_PIXEL_OFF, pix[i]);
    rd(FMAC_STATUS_OFF, stat(9'd4, 9'd6, 1'b1, 1'b0));
    rd(FMAC_PIXEL_OFF, 32'h0);
    // wrap enabled: two pixels bring both counters back to start
    wr(FMAC_CTRL_OFF, 32'h1);
    wr(FMAC_COL_WIN_OFF, win(9'd0, 9'd1));
    wr(FMAC_PAGE_WIN_OFF, win(9'd0, 9'd0));
    wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_MEM_WRITE});
    wr(FMAC_PIXEL_OFF, $urandom());
    wr(FMAC_PIXEL_OFF, $urandom());
    rd(FMAC_STATUS_OFF, stat(9'd0, 9'd0, 1'b0, 1'b0));
    // every orientation: write at counter (3,7), read back at the physical spot
    for (int o = 0; o < 8; o++) begin
      wr(FMAC_CTRL_OFF, o << 1);
      wr(FMAC_COL_WIN_OFF, win(9'd3, 9'd3));
      wr(FMAC_PAGE_WIN_OFF, win(9'd7, 9'd7));
      wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_MEM_WRITE});
      v = $urandom() & 32'h00FFFFFF;
      wr(FMAC_PIXEL_OFF, v);
      x = o[0] ? 9'd7 : 9'd3;
      y = o[0] ? 9'd3 : 9'd7;
      if (o[1]) x = 9'd319 - x;
      if (o[2]) y = 9'd479 - y;
      wr(FMAC_CTRL_OFF, 32'h0);
      wr(FMAC_COL_WIN_OFF, win(x, x));
      wr(FMAC_PAGE_WIN_OFF, win(y, y));
      wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_MEM_READ});
      rd(FMAC_PIXEL_OFF, v);
    end
    // tear output: off, first mode, second mode, off again
    count_rises(n);
    check("tear rises disabled", n, 32'd0);
    wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_TEAR_ON});
    rd(FMAC_STATUS_OFF, stat(x, y, 1'b1, 1'b1));
    host.wait_tear();
    check("tear pin", {31'h0, tear_sync_pin}, 32'h1);
    count_rises(n);
    check("tear rises mode1", n, 32'd1);
    wr(FMAC_CTRL_OFF, 32'h10);
    count_rises(n);
    check("tear rises mode2", n, 32'd480);
    wr(FMAC_CMD_OFF, {24'h0, FMAC_CMD_TEAR_OFF});
    repeat (3) @(posedge pclk);
    count_rises(n);
    check("tear rises off", n, 32'd0);
    // second reset in mid-run restores the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(FMAC_CTRL_OFF, 32'h0);
    rd(FMAC_COL_WIN_OFF, win(9'h000, 9'h13F));
    rd(FMAC_STATUS_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule
`default_nettype wire
